// File: shared/link_err_cfg.svh
// register map, field positions and reset values of the link error block
// assumes a classic wishbone slave with one 32-bit word per register
`ifndef LINK_ERR_CFG_SVH
`define LINK_ERR_CFG_SVH

// ----------------------------------------
// register indices, byte address = 4 * index
// ----------------------------------------
`define IDX_MAIN_CTL 3'h0
`define IDX_IRQ_TMO_CTL 3'h1
`define IDX_ERR_STAT 3'h2
`define IDX_LINK_STAT 3'h3
`define IDX_LAST 3'h3

// ----------------------------------------
// field positions
// ----------------------------------------
`define B_LINK_EN 7
`define F_CLK_DIV 1:0
`define B_EXT_IE 7
`define F_TMO_SET 3:0
`define B_ERR_SUM 7
`define B_ACK_ERR 6
`define B_CANCEL 5
`define B_TIMEOUT 4
`define B_TXN_ERR 3
`define B_PAR_ERR 2
`define F_RX_PAR 1:0
`define B_EXT_IF 7
`define B_BUSY 6

// ----------------------------------------
// reset values and constants
// ----------------------------------------
`define RST_BYTE 8'h00
`define RST_DIV 2'h0
`define RST_TMO 4'h0
`define RST_PAR 2'h0
`define DAT_ALL_HIGH 8'hFF
`define IDLE_CMD 8'h00
`define RST_WORD 32'h0000_0000

`endif

// File: shared/link_err_pkg.sv
// types shared by the link error block
// assumes link_err_cfg.svh supplies the numeric constants
package link_err_pkg;

  typedef enum logic [1:0] {
    TO_IDLE = 2'b01,
    TO_WAIT = 2'b10
  } tmo_state_t;

  typedef logic [7:0] byte_t;

endpackage : link_err_pkg

// File: verilog/pin_sync2.sv
// two-flop synchroniser for pins that arrive from outside the bus clock domain
// assumes the inputs are quasi-static against the bus clock period
`timescale 1ns/1ps
module pin_sync2 #(
  parameter int W = 13
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule : pin_sync2

// File: verilog/link_clk_div.sv
// link clock divider: bus clock divided by div + 1, with a one-cycle tick
// assumes div is only changed while run is low
`timescale 1ns/1ps
`include "link_err_cfg.svh"
module link_clk_div (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [1:0] div,
  output logic tick,
  output logic link_clk
);
  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;

  // tick marks the last bus cycle of each link clock period
  assign tick = run && (cnt_reg == div);

  always_comb begin
    cnt_next = cnt_reg + 2'h1;
    if (!run || tick) begin
      cnt_next = 2'h0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= `RST_DIV;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // high for the first bus cycle of a period, so at most half duty when div is above zero;
  // divide by one cannot come from a flop, the pin then simply stays high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link_clk <= 1'b0;
    end else begin
      link_clk <= run && ((div == `RST_DIV) || (cnt_next == 2'h0));
    end
  end
endmodule : link_clk_div

// File: verilog/link_err_top.sv
// timeout and error status logic of a die-to-die link initiator
// assumes a transaction sequencer on the same clock supplies the
// request, last-transfer, acknowledge and parity strobes
//
// Operation
// - pass target external interrupt to cpu only while its enable bit 7 is set
// - count link clocks after last transfer, timeout when count exceeds setting
// - a detected acknowledge timeout sets status bit 4
// - timeout setting writable until link enabled, always in special modes
// - after link enable is set, write-once fields ignore writes in normal modes
// - setting one to fifteen allows that many wait states before timeout
// - summary bit 7 sets whenever any of the five error flags sets
// - summary flag drives a cpu interrupt that nothing masks locally
// - writing 1 to the summary flag clears it, writing 0 keeps it
// - acknowledge error bit 6 when not all data inputs high at acknowledge
// - five error flags are read-only and clear with the summary flag
// - while summary pending, new requests are cancelled, idle sent, bit 5 set
// - transaction error bit 3 when target signals error at acknowledge
// - parity error bit 2 on parity mismatch in received data
// - received parity bits shown read-only in status bits 1 and 0
// - link clock is bus clock divided by 1 to 4 from a two-bit code
// - once enabled, data lines driven low with idle and link clock runs
`timescale 1ns/1ps
`include "link_err_cfg.svh"
module link_err_top (
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire logic WB_CYC,
  input wire logic WB_STB,
  input wire logic WB_WE,
  input wire logic [4:0] WB_ADR,
  input wire logic [3:0] WB_SEL,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK,
  input wire logic SPECIAL_MODE,
  input wire logic TXN_REQ,
  output logic TXN_GO,
  output logic TXN_CANCEL,
  input wire logic LAST_XFER,
  input wire logic ACK_SEEN,
  input wire logic PAR_STROBE,
  output logic LINK_TICK,
  output logic LINK_CLK,
  input wire logic [7:0] LINK_DAT_I,
  output logic [7:0] LINK_DAT_O,
  output logic LINK_DAT_OE,
  input wire logic LINK_ERR_I,
  input wire logic [1:0] LINK_PAR_I,
  input wire logic LINK_INT_I,
  output logic EXT_IRQ,
  output logic ERR_IRQ
);

  // ----------------------------------------
  // reset release and pin synchronisers
  // ----------------------------------------
  logic rst_meta_reg;
  logic rst_n;
  logic [12:0] pins_s;
  link_err_pkg::byte_t dat_s;
  logic [1:0] par_s;
  logic err_s;
  logic int_s;
  logic special_s;

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  pin_sync2 #(.W(13)) u_sync (
    .clk(CLK_SYS),
    .rst_n(rst_n),
    .d({LINK_DAT_I, LINK_PAR_I, LINK_ERR_I, LINK_INT_I, SPECIAL_MODE}),
    .q(pins_s)
  );

  assign {dat_s, par_s, err_s, int_s, special_s} = pins_s;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // one parity bit per nibble, even parity
  function automatic logic par_mismatch(input link_err_pkg::byte_t d, input logic [1:0] p);
    par_mismatch = ((^d[3:0]) != p[0]) || ((^d[7:4]) != p[1]);
  endfunction : par_mismatch

  // ----------------------------------------
  // wishbone slave
  // ----------------------------------------
  logic req;
  logic ack_reg;
  logic wr_en;
  logic [2:0] idx;
  logic [31:0] rdata_reg;
  link_err_pkg::byte_t rd_byte;

  assign req = WB_CYC && WB_STB;
  assign idx = WB_ADR[4:2];
  // a write lands on the edge where the master samples ack
  assign wr_en = req && WB_WE && ack_reg && WB_SEL[0];
  assign WB_ACK = ack_reg;
  assign WB_DAT_O = rdata_reg;

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req && !ack_reg;
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  logic en_reg;
  logic [1:0] div_reg;
  logic ie_reg;
  logic [3:0] tmo_reg;
  logic locked;

  // write-once fields freeze once the link runs, except in special modes
  assign locked = en_reg && !special_s;

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      en_reg <= 1'b0;
      div_reg <= `RST_DIV;
    end else if (wr_en && (idx == `IDX_MAIN_CTL) && !locked) begin
      en_reg <= WB_DAT_I[`B_LINK_EN];
      div_reg <= WB_DAT_I[`F_CLK_DIV];
    end
  end

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      ie_reg <= 1'b0;
      tmo_reg <= `RST_TMO;
    end else if (wr_en && (idx == `IDX_IRQ_TMO_CTL)) begin
      ie_reg <= WB_DAT_I[`B_EXT_IE];
      if (!locked) begin
        tmo_reg <= WB_DAT_I[`F_TMO_SET];
      end
    end
  end

  // ----------------------------------------
  // link clock and idle drive
  // ----------------------------------------
  link_clk_div u_div (
    .clk(CLK_SYS),
    .rst_n(rst_n),
    .run(en_reg),
    .div(div_reg),
    .tick(LINK_TICK),
    .link_clk(LINK_CLK)
  );

  // sequencing is outside this block, so the lines only ever carry idle
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      LINK_DAT_O <= `IDLE_CMD;
      LINK_DAT_OE <= 1'b0;
    end else begin
      LINK_DAT_O <= `IDLE_CMD;
      LINK_DAT_OE <= en_reg;
    end
  end

  // ----------------------------------------
  // acknowledge timeout
  // ----------------------------------------
  link_err_pkg::tmo_state_t state_reg;
  link_err_pkg::tmo_state_t state_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic ack_evt;
  logic tmo_evt;

  assign ack_evt = (state_reg == link_err_pkg::TO_WAIT) && ACK_SEEN;
  // the target may stretch by tmo_reg wait states; one more tick is late
  assign tmo_evt = (state_reg == link_err_pkg::TO_WAIT) && LINK_TICK && !ACK_SEEN
                   && (cnt_reg == tmo_reg);

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      link_err_pkg::TO_IDLE: begin
        if (LAST_XFER) begin
          state_next = link_err_pkg::TO_WAIT;
          cnt_next = 4'h0;
        end
      end
      link_err_pkg::TO_WAIT: begin
        if (LAST_XFER) begin
          cnt_next = 4'h0;
        end else if (ACK_SEEN || tmo_evt) begin
          state_next = link_err_pkg::TO_IDLE;
        end else if (LINK_TICK) begin
          cnt_next = cnt_reg + 4'h1;
        end
      end
      default: begin
        state_next = link_err_pkg::TO_IDLE;
        cnt_next = 4'h0;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= link_err_pkg::TO_IDLE;
      cnt_reg <= 4'h0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  // ----------------------------------------
  // error flags
  // ----------------------------------------
  logic sum_reg;
  logic ackerr_reg;
  logic cncl_reg;
  logic time_reg;
  logic terr_reg;
  logic parerr_reg;
  logic [1:0] prx_reg;
  logic clr;
  logic ackerr_evt;
  logic terr_evt;
  logic par_evt;
  logic cncl_evt;
  logic any_evt;

  assign clr = wr_en && (idx == `IDX_ERR_STAT) && WB_DAT_I[`B_ERR_SUM];
  assign ackerr_evt = ack_evt && (dat_s != `DAT_ALL_HIGH);
  assign terr_evt = ack_evt && err_s;
  assign par_evt = PAR_STROBE && par_mismatch(dat_s, par_s);
  assign cncl_evt = TXN_REQ && sum_reg;
  assign any_evt = ackerr_evt || terr_evt || par_evt || cncl_evt || tmo_evt;

  // a new request goes out only while no error is pending
  assign TXN_GO = TXN_REQ && !sum_reg;
  assign TXN_CANCEL = cncl_evt;

  // set wins over a same-cycle clear so no event is lost
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      sum_reg <= 1'b0;
      ackerr_reg <= 1'b0;
      cncl_reg <= 1'b0;
      time_reg <= 1'b0;
      terr_reg <= 1'b0;
      parerr_reg <= 1'b0;
    end else begin
      sum_reg <= any_evt || (sum_reg && !clr);
      ackerr_reg <= ackerr_evt || (ackerr_reg && !clr);
      cncl_reg <= cncl_evt || (cncl_reg && !clr);
      time_reg <= tmo_evt || (time_reg && !clr);
      terr_reg <= terr_evt || (terr_reg && !clr);
      parerr_reg <= par_evt || (parerr_reg && !clr);
    end
  end

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      prx_reg <= `RST_PAR;
    end else if (PAR_STROBE) begin
      prx_reg <= par_s;
    end
  end

  // ----------------------------------------
  // interrupt outputs
  // ----------------------------------------
  assign ERR_IRQ = sum_reg;

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      EXT_IRQ <= 1'b0;
    end else begin
      EXT_IRQ <= int_s && ie_reg;
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  always_comb begin
    rd_byte = `RST_BYTE;
    case (idx)
      `IDX_MAIN_CTL: begin
        rd_byte[`B_LINK_EN] = en_reg;
        rd_byte[`F_CLK_DIV] = div_reg;
      end
      `IDX_IRQ_TMO_CTL: begin
        rd_byte[`B_EXT_IE] = ie_reg;
        rd_byte[`F_TMO_SET] = tmo_reg;
      end
      `IDX_ERR_STAT: begin
        rd_byte[`B_ERR_SUM] = sum_reg;
        rd_byte[`B_ACK_ERR] = ackerr_reg;
        rd_byte[`B_CANCEL] = cncl_reg;
        rd_byte[`B_TIMEOUT] = time_reg;
        rd_byte[`B_TXN_ERR] = terr_reg;
        rd_byte[`B_PAR_ERR] = parerr_reg;
        rd_byte[`F_RX_PAR] = prx_reg;
      end
      `IDX_LINK_STAT: begin
        rd_byte[`B_EXT_IF] = int_s;
        rd_byte[`B_BUSY] = (state_reg == link_err_pkg::TO_WAIT);
      end
      default: begin
        rd_byte = `RST_BYTE;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= `RST_WORD;
    end else if (req && !ack_reg) begin
      rdata_reg <= {24'h00_0000, rd_byte};
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  ext_irq_gate_a: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    ##1 EXT_IRQ == $past(int_s && ie_reg))
    else $error("external interrupt not gated by its enable");

  tmo_fires_a: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    (state_reg == link_err_pkg::TO_WAIT && LINK_TICK && !ACK_SEEN && !LAST_XFER
     && cnt_reg == tmo_reg) |=> time_reg && sum_reg && state_reg == link_err_pkg::TO_IDLE)
    else $error("timeout not flagged when count passed setting");

  tmo_early_a: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    (state_reg == link_err_pkg::TO_WAIT && cnt_reg < tmo_reg && !time_reg)
    |=> !time_reg)
    else $error("timeout flagged within allowed wait states");

  tmo_restart_a: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    LAST_XFER |=> cnt_reg == 4'h0 && state_reg == link_err_pkg::TO_WAIT)
    else $error("timeout count did not restart");

  write_once_a: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    (locked && wr_en) |=> $stable(tmo_reg) && $stable(div_reg) && en_reg)
    else $error("write-once field changed while locked");

  sum_covers_a: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    (ackerr_reg || cncl_reg || time_reg || terr_reg || parerr_reg) |-> sum_reg && ERR_IRQ)
    else $error("error flag set without summary");

  w1c_clear_a: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    (clr && !any_evt) |=> !sum_reg && !ackerr_reg && !cncl_reg && !time_reg
    && !terr_reg && !parerr_reg)
    else $error("flags not cleared together");

  w0_keep_a: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    (sum_reg && wr_en && idx == `IDX_ERR_STAT && !WB_DAT_I[`B_ERR_SUM]) |=> sum_reg)
    else $error("summary lost on write of zero");

  cancel_pending_a: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    (TXN_REQ && sum_reg) |-> TXN_CANCEL && !TXN_GO ##1 cncl_reg)
    else $error("request not cancelled while error pending");

  ack_check_a: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    (ack_evt && (dat_s != `DAT_ALL_HIGH || err_s)) |=> (ackerr_reg || terr_reg) && sum_reg)
    else $error("acknowledge fault not flagged");

  par_flag_a: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    PAR_STROBE |=> parerr_reg == ($past(par_evt) || $past(parerr_reg && !clr))
    && prx_reg == $past(par_s))
    else $error("parity flag or received parity wrong");

endmodule : link_err_top

// File: verif/link_target_model.sv
// behavioural model of the target logic on the companion die
// assumes the bench sets the pin levels and the device drives idle when enabled
`timescale 1ns/1ps
module link_target_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic drive,
  input wire logic [7:0] ack_dat,
  input wire logic err,
  input wire logic [1:0] par,
  input wire logic irq,
  input wire logic dev_oe,
  input wire logic [7:0] dev_dat,
  output logic [7:0] dat_line,
  output logic err_line,
  output logic [1:0] par_line,
  output logic int_line
);
  // ----------------------------------------
  // line levels
  // ----------------------------------------
  logic [7:0] last_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_reg <= 8'h00;
    end else begin
      last_reg <= dat_line;
    end
  end
  // a released data line flips each cycle so a stale value never looks valid
  assign dat_line = drive ? ack_dat : (dev_oe ? dev_dat : ~last_reg);
  // error and parity pins assumed pulled low when not driven
  assign err_line = drive & err;
  assign par_line = drive ? par : 2'h0;
  assign int_line = irq;
endmodule : link_target_model

// File: verif/testbench.sv
// self-checking bench for the link timeout and error status block
// assumes the wishbone map and strobe timing of the designer's hand-over
`timescale 1ns/1ps
module testbench;
  // ----------------------------------------
  // stimulus and wiring
  // ----------------------------------------
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, special = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic txn_req = 1'b0, last_xfer = 1'b0, ack_seen = 1'b0, par_strobe = 1'b0;
  logic t_drive = 1'b0, t_err = 1'b0, t_irq = 1'b0;
  logic [7:0] t_dat = 8'h00;
  logic [1:0] t_par = 2'h0;
  logic [31:0] rdat;
  logic ack, txn_go, txn_cancel, link_tick, link_clk, dat_oe, ext_irq, err_irq;
  logic [7:0] dev_dat, dat_line;
  logic err_line, int_line;
  logic [1:0] par_line;
  int err_total = 0;
  int checks_done = 0;
  int cycles = 0;

  always #20 clk_sys = ~clk_sys;

  link_err_top dut_u (.CLK_SYS(clk_sys), .ARST_N(arst_n), .WB_CYC(cyc), .WB_STB(stb),
    .WB_WE(we), .WB_ADR(adr), .WB_SEL(4'h1), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
    .WB_ACK(ack), .SPECIAL_MODE(special), .TXN_REQ(txn_req), .TXN_GO(txn_go),
    .TXN_CANCEL(txn_cancel), .LAST_XFER(last_xfer), .ACK_SEEN(ack_seen),
    .PAR_STROBE(par_strobe), .LINK_TICK(link_tick), .LINK_CLK(link_clk),
    .LINK_DAT_I(dat_line), .LINK_DAT_O(dev_dat), .LINK_DAT_OE(dat_oe),
    .LINK_ERR_I(err_line), .LINK_PAR_I(par_line), .LINK_INT_I(int_line),
    .EXT_IRQ(ext_irq), .ERR_IRQ(err_irq));

  link_target_model target_u (.clk(clk_sys), .rst_n(arst_n), .drive(t_drive),
    .ack_dat(t_dat), .err(t_err), .par(t_par), .irq(t_irq), .dev_oe(dat_oe),
    .dev_dat(dev_dat), .dat_line(dat_line), .err_line(err_line), .par_line(par_line),
    .int_line(int_line));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // classic cycle: hold the request until the edge that samples ack high
  task automatic wb_xfer(input logic w, input logic [4:0] a, input logic [7:0] d,
                         output logic [7:0] r);
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h00_0000, d};
    // ack is read at the edge itself, which is the value the slave sampled
    do begin
      @(posedge clk_sys);
    end while (ack !== 1'b1);
    r = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb_xfer

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] r;
    wb_xfer(1'b1, a, d, r);
  endtask : wr

  task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp, input string name);
    logic [7:0] r;
    wb_xfer(1'b0, a, 8'h00, r);
    chk(name, r, exp);
  endtask : rd_chk

  // one-cycle sequencer strobe: 0 last transfer, 1 ack, 2 parity, 3 request
  task automatic pulse(input int k);
    @(posedge clk_sys);
    case (k)
      0: last_xfer <= 1'b1;
      1: ack_seen <= 1'b1;
      2: par_strobe <= 1'b1;
      default: txn_req <= 1'b1;
    endcase
    @(posedge clk_sys);
    {last_xfer, ack_seen, par_strobe, txn_req} <= 4'h0;
  endtask : pulse

  // last transfer, then acknowledge on the very next edge with no wait state
  task automatic xfer_ack();
    @(posedge clk_sys);
    last_xfer <= 1'b1;
    @(posedge clk_sys);
    last_xfer <= 1'b0;
    ack_seen <= 1'b1;
    @(posedge clk_sys);
    ack_seen <= 1'b0;
  endtask : xfer_ack

  task automatic wait_ticks(input int n);
    int m;
    m = 0;
    while (m < n) begin
      @(negedge clk_sys);
      if (link_tick === 1'b1) m++;
    end
  endtask : wait_ticks

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      test_done();
    end
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    int n;
    int m;
    repeat (16) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    for (int a = 0; a < 5; a++) rd_chk(5'(a * 4), 8'h00, "reset value");
    chk("clock idle", {7'h00, link_clk}, 8'h00);
    $display("test reset finished");

    wr(5'h04, 8'h82);
    rd_chk(5'h04, 8'h82, "irq timeout control");
    t_irq <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chk("ext irq enabled", {7'h00, ext_irq}, 8'h01);
    wr(5'h04, 8'h02);
    repeat (3) @(posedge clk_sys);
    chk("ext irq blocked", {7'h00, ext_irq}, 8'h00);
    $display("test ext irq finished");

    special <= 1'b1;
    repeat (4) @(posedge clk_sys);
    for (int d = 0; d < 4; d++) begin
      wr(5'h00, 8'(d));
      wr(5'h00, 8'(8'h80 | d));
      repeat (4) @(posedge clk_sys);
      n = 0;
      m = 0;
      repeat (12) begin
        @(negedge clk_sys);
        if (link_tick === 1'b1) n++;
        if (link_clk === 1'b1) m++;
      end
      chk("ticks per 12 cycles", 8'(n), 8'(12 / (d + 1)));
      chk("clock highs per 12 cycles", 8'(m), 8'(12 / (d + 1)));
    end
    wr(5'h00, 8'h81);
    chk("data enable", {7'h00, dat_oe}, 8'h01);
    chk("idle data", dev_dat, 8'h00);
    wr(5'h04, 8'h03);
    rd_chk(5'h04, 8'h03, "special write");
    special <= 1'b0;
    repeat (4) @(posedge clk_sys);
    wr(5'h04, 8'h0F);
    rd_chk(5'h04, 8'h03, "write once setting");
    wr(5'h00, 8'h02);
    rd_chk(5'h00, 8'h81, "write once enable");
    $display("test config finished");

    // setting 3: ack after three wait ticks, restart in between
    t_drive <= 1'b1;
    t_dat <= 8'hFF;
    repeat (4) @(posedge clk_sys);
    pulse(0);
    wait_ticks(3);
    pulse(0);
    wait_ticks(3);
    pulse(1);
    rd_chk(5'h08, 8'h00, "ack in time");
    pulse(0);
    rd_chk(5'h0C, 8'hC0, "busy and ext int");
    wait_ticks(4);
    repeat (3) @(posedge clk_sys);
    rd_chk(5'h08, 8'h90, "timeout status");
    chk("error irq", {7'h00, err_irq}, 8'h01);
    $display("test timeout finished");

    @(posedge clk_sys);
    txn_req <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk("cancel", {6'h00, txn_cancel, txn_go}, 8'h02);
    @(posedge clk_sys);
    txn_req <= 1'b0;
    rd_chk(5'h08, 8'hB0, "cancel flag");
    wr(5'h08, 8'h7F);
    rd_chk(5'h08, 8'hB0, "write zero to summary");
    wr(5'h08, 8'h80);
    rd_chk(5'h08, 8'h00, "cleared");
    chk("error irq off", {7'h00, err_irq}, 8'h00);
    @(posedge clk_sys);
    txn_req <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk("go", {6'h00, txn_cancel, txn_go}, 8'h01);
    @(posedge clk_sys);
    txn_req <= 1'b0;
    $display("test cancel finished");

    // setting zero: an ack right after the last transfer is in time
    special <= 1'b1;
    repeat (4) @(posedge clk_sys);
    wr(5'h04, 8'h00);
    special <= 1'b0;
    repeat (4) @(posedge clk_sys);
    xfer_ack();
    rd_chk(5'h08, 8'h00, "ack with no wait");
    pulse(0);
    wait_ticks(1);
    repeat (3) @(posedge clk_sys);
    rd_chk(5'h08, 8'h90, "zero setting timeout");
    wr(5'h08, 8'h80);
    $display("test zero setting finished");

    t_dat <= 8'hEF;
    t_err <= 1'b1;
    repeat (4) @(posedge clk_sys);
    xfer_ack();
    rd_chk(5'h08, 8'hC8, "ack and target error");
    wr(5'h08, 8'h80);
    t_dat <= 8'h31;
    t_err <= 1'b0;
    t_par <= 2'h1;
    repeat (4) @(posedge clk_sys);
    pulse(2);
    rd_chk(5'h08, 8'h01, "parity good");
    t_par <= 2'h2;
    repeat (4) @(posedge clk_sys);
    pulse(2);
    rd_chk(5'h08, 8'h86, "parity error");
    $display("test errors finished");
    test_done();
  end
endmodule : testbench
